/* aux_sensor_i2c_master.v */
// auxiliary sensor bus master with pass-through switch
`timescale 1ns/1ps
`default_nettype none
`include "aux_i2c_consts.vh"

// Operation
// - primary port only answers, never initiates
// - address lsb follows sampled select pin
// - master mode drives transactions to sensors
// - pass-through disables master, joins buses
// - primary port keeps answering in pass-through
// - up to 24 bytes across four channels
// - channel four: single byte read/write only
// - single or burst reads of consecutive registers
// - no bypass while primary port in spi mode
// - channels reach any address and register
// - channel 0-3 data to registers, optional fifo
// - missing acknowledge raises error flag
// - lost arbitration and nack reported as errors
module aux_sensor_i2c_master #(
  parameter HALF_CYC = `HALF_PERIOD_CYC
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        ce,
  input  wire        address_select_pin,
  input  wire        spi_mode,
  input  wire        bypass_en,
  input  wire        master_en,
  input  wire        start_req,
  input  wire [2:0]  chan,
  input  wire        rd_not_wr,
  input  wire [6:0]  dev_addr,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  wr_data,
  input  wire [4:0]  rd_len,
  input  wire        fifo_en,
  input  wire        pri_scl_in,
  input  wire        pri_sda_in,
  output wire        pri_scl_out,
  output wire        pri_scl_oe,
  output wire        pri_sda_out,
  output wire        pri_sda_oe,
  input  wire        aux_clock_line_in,
  input  wire        aux_data_line_in,
  output wire        aux_clock_line_out,
  output reg         aux_clock_line_oe,
  output wire        aux_data_line_out,
  output reg         aux_data_line_oe,
  output wire [6:0]  primary_addr,
  output wire        bypass_active,
  output reg         busy,
  output reg         done,
  output reg         nack_err,
  output reg         arb_lost,
  output reg  [7:0]  rd_byte,
  output reg  [4:0]  rd_index,
  output reg         rd_valid,
  output reg  [2:0]  rd_chan,
  output reg         fifo_push
);

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: first stage feeds only second stage
  reg [1:0] sel_s, acl_s, ada_s, pcl_s, pda_s;
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sel_s <= 2'h0;
      acl_s <= 2'h3;
      ada_s <= 2'h3;
      pcl_s <= 2'h3;
      pda_s <= 2'h3;
    end
    else if (ce)
    begin
      sel_s <= {sel_s[0], address_select_pin};
      acl_s <= {acl_s[0], aux_clock_line_in};
      ada_s <= {ada_s[0], aux_data_line_in};
      pcl_s <= {pcl_s[0], pri_scl_in};
      pda_s <= {pda_s[0], pri_sda_in};
    end
  end

  // target address of the primary port, never a master there
  assign primary_addr = {`PRIMARY_ADDR_HI, sel_s[1]};
  assign pri_scl_out  = 1'b0;
  assign pri_scl_oe   = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // bypass switch: spi mode shares the primary pins, so no bypass then
  assign bypass_active = bypass_en & ~spi_mode & ~busy;
  // primary slave logic lives elsewhere and stays live in bypass
  assign pri_sda_out = 1'b0;
  assign pri_sda_oe  = 1'b0;
  // open drain: drive low only, level comes from the joined wire
  assign aux_clock_line_out = 1'b0;
  assign aux_data_line_out  = 1'b0;

  ////////////////////////////////////////////////////////////////////////
  // master sequencer
  reg [3:0] st_q;
  reg [7:0] div_q;
  reg       ph_q;   // 0: clock low half, 1: clock high half
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg [6:0] dev_q;
  reg [7:0] regq;
  reg [7:0] wd_q;
  reg       rd_q;
  reg [4:0] len_q;
  reg [4:0] cnt_q;
  reg [2:0] ch_q;
  reg       fen_q;
  reg       sda_drv;  // 1 = pull data low
  reg       scl_drv;  // 1 = pull clock low

  wire tick = (div_q == HALF_CYC - 8'h01);
  wire master_ok = master_en & ~bypass_en;

  // length clamp: channel four one byte, others at most 24
  function [4:0] clamp_len;
    input [2:0] c;
    input [4:0] l;
    begin
      if (c == `SINGLE_CHAN)
        clamp_len = 5'h01;
      else if (l == 5'h00)
        clamp_len = 5'h01;
      else if (l > `DATA_BYTES_MAX)
        clamp_len = `DATA_BYTES_MAX;
      else
        clamp_len = l;
    end
  endfunction

  // mirror drive states to pins, and never in bypass
  always @*
  begin
    aux_clock_line_oe = scl_drv & ~bypass_active;
    aux_data_line_oe  = sda_drv & ~bypass_active;
  end

  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= `ST_IDLE; div_q <= 8'h00; ph_q <= 1'b0; bit_q <= 4'h0;
      sh_q <= 8'h00; dev_q <= 7'h00; regq <= 8'h00; wd_q <= 8'h00;
      rd_q <= 1'b0; len_q <= 5'h00; cnt_q <= 5'h00; ch_q <= 3'h0;
      fen_q <= 1'b0; sda_drv <= 1'b0; scl_drv <= 1'b0; busy <= 1'b0;
      done <= 1'b0; nack_err <= 1'b0; arb_lost <= 1'b0; rd_byte <= 8'h00;
      rd_index <= 5'h00; rd_valid <= 1'b0; rd_chan <= 3'h0; fifo_push <= 1'b0;
    end
    else if (ce)
    begin
      done <= 1'b0;
      nack_err <= 1'b0;
      arb_lost <= 1'b0;
      rd_valid <= 1'b0;
      fifo_push <= 1'b0;
      div_q <= tick ? 8'h00 : div_q + 8'h01;
      case (st_q)
        `ST_IDLE:
        begin
          sda_drv <= 1'b0;
          scl_drv <= 1'b0;
          div_q <= 8'h00;
          ph_q <= 1'b1;
          if (start_req && master_ok && chan <= `SINGLE_CHAN)
          begin
            busy <= 1'b1; dev_q <= dev_addr; regq <= reg_addr; wd_q <= wr_data;
            rd_q <= rd_not_wr; len_q <= clamp_len(chan, rd_len); cnt_q <= 5'h00;
            ch_q <= chan; fen_q <= fifo_en & (chan != `SINGLE_CHAN);
            st_q <= `ST_START;
          end
        end
        `ST_START, `ST_RSTART:
          if (tick)
          begin
            // a re-start first lets the clock rise with data released; then
            // data falls while clock high, then clock falls
            if (scl_drv)
              scl_drv <= 1'b0;
            else if (!sda_drv)
              sda_drv <= 1'b1;
            else
            begin
              scl_drv <= 1'b1; ph_q <= 1'b0; bit_q <= 4'h0;
              sh_q <= (st_q == `ST_START) ? {dev_q, 1'b0} : {dev_q, 1'b1};
              st_q <= (st_q == `ST_START) ? `ST_ADDR : `ST_RADDR;
            end
          end
        `ST_STOP:
          if (tick)
          begin
            // data low under a low clock, clock up, then data up: a line never
            // moves in the cycle in which the other one does
            if (scl_drv && !sda_drv)
              sda_drv <= 1'b1;
            else if (scl_drv)
              scl_drv <= 1'b0;
            else
            begin
              sda_drv <= 1'b0;
              busy <= 1'b0;
              done <= 1'b1;
              st_q <= `ST_IDLE;
            end
          end
        default:
          if (tick)
          begin
            if (!ph_q)
            begin
              // low half end: data already settled, let the clock rise
              scl_drv <= 1'b0;
              ph_q <= 1'b1;
            end
            else
            begin
              // high half end: sample and advance
              scl_drv <= 1'b1; ph_q <= 1'b0;
              if (!sda_drv && !ada_s[1] && (st_q == `ST_ADDR || st_q == `ST_REG ||
                  st_q == `ST_WDATA || st_q == `ST_RADDR))
              begin
                arb_lost <= 1'b1; sda_drv <= 1'b0; scl_drv <= 1'b0;
                busy <= 1'b0; st_q <= `ST_IDLE;
              end
              else case (st_q)
                `ST_ADDR, `ST_REG, `ST_WDATA, `ST_RADDR, `ST_RDATA:
                begin
                  sh_q <= {sh_q[6:0], ada_s[1]};
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'h7) st_q <= st_q + 4'h1;
                end
                `ST_ADDR_ACK, `ST_REG_ACK, `ST_WDATA_ACK, `ST_RADDR_ACK:
                begin
                  bit_q <= 4'h0;
                  if (ada_s[1])
                  begin
                    nack_err <= 1'b1; st_q <= `ST_STOP;
                  end
                  else if (st_q == `ST_ADDR_ACK) begin sh_q <= regq; st_q <= `ST_REG; end
                  else if (st_q == `ST_REG_ACK)
                  begin
                    sh_q <= wd_q;
                    st_q <= rd_q ? `ST_RSTART : `ST_WDATA;
                  end
                  else if (st_q == `ST_WDATA_ACK) st_q <= `ST_STOP;
                  else st_q <= `ST_RDATA;
                end
                `ST_RDATA_ACK:
                begin
                  bit_q <= 4'h0;
                  st_q <= (cnt_q == len_q) ? `ST_STOP : `ST_RDATA;
                end
                default: st_q <= `ST_IDLE;
              endcase
              if (st_q == `ST_RDATA && bit_q == 4'h7)
              begin
                // consecutive bytes of a burst land by index
                rd_byte <= {sh_q[6:0], ada_s[1]}; rd_index <= cnt_q;
                rd_chan <= ch_q; rd_valid <= 1'b1; fifo_push <= fen_q;
                cnt_q <= cnt_q + 5'h01;
              end
            end
          end
      endcase
      // data moves only mid low half, clear of both clock edges; needs HALF_CYC >= 3
      if (!ph_q && div_q == (HALF_CYC >> 1))
      begin
        case (st_q)
          `ST_ADDR, `ST_REG, `ST_WDATA, `ST_RADDR: sda_drv <= ~sh_q[7];
          `ST_RDATA_ACK: sda_drv <= (cnt_q != len_q); // ack all but last
          `ST_ADDR_ACK, `ST_REG_ACK, `ST_WDATA_ACK, `ST_RADDR_ACK, `ST_RDATA: sda_drv <= 1'b0;
          default: ;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

/* aux_i2c_consts.vh */
// constants for the auxiliary sensor bus logic
`ifndef AUX_I2C_CONSTS_VH
`define AUX_I2C_CONSTS_VH

`define PRIMARY_ADDR_HI   6'h34
`define CHAN_COUNT        4
`define DATA_BYTES_MAX    5'h18
`define SINGLE_CHAN       3'h4
`define HALF_PERIOD_CYC   8'h32
`define ST_IDLE           4'h0
`define ST_START          4'h1
`define ST_ADDR           4'h2
`define ST_ADDR_ACK       4'h3
`define ST_REG            4'h4
`define ST_REG_ACK        4'h5
`define ST_WDATA          4'h6
`define ST_WDATA_ACK      4'h7
`define ST_RSTART         4'h8
`define ST_RADDR          4'h9
`define ST_RADDR_ACK      4'ha
`define ST_RDATA          4'hb
`define ST_RDATA_ACK      4'hc
`define ST_STOP           4'hd

`endif

/* aux_master_chk_asserts.sv */
// port assertions for the auxiliary sensor bus master
`timescale 1ns/1ps
`default_nettype none
`include "aux_i2c_consts.vh"
module aux_master_chk #(
  parameter HALF_CYC = `HALF_PERIOD_CYC
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic       ce,
  input wire logic       address_select_pin,
  input wire logic       spi_mode,
  input wire logic       bypass_en,
  input wire logic       master_en,
  input wire logic       start_req,
  input wire logic [2:0] chan,
  input wire logic       pri_scl_oe,
  input wire logic       pri_sda_oe,
  input wire logic       aux_clock_line_oe,
  input wire logic       aux_data_line_oe,
  input wire logic [6:0] primary_addr,
  input wire logic       bypass_active,
  input wire logic       busy,
  input wire logic       done,
  input wire logic       nack_err,
  input wire logic       rd_valid,
  input wire logic [4:0] rd_index,
  input wire logic [2:0] rd_chan,
  input wire logic       fifo_push
);
  // a stop after a refused byte takes three half periods; one spare
  localparam int STOP_MAX = 4 * HALF_CYC;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  pri_quiet_a: assert property (!pri_scl_oe && !pri_sda_oe)
    else $error("primary port driven");
  addr_pin_a: assert property (!$past(rst, 3) && $stable(address_select_pin)
    && address_select_pin == $past(address_select_pin, 2)
    |-> primary_addr == {`PRIMARY_ADDR_HI, address_select_pin}) else $error("address lsb wrong");
  bypass_eq_a: assert property (bypass_active == (bypass_en && !spi_mode && !busy))
    else $error("bypass state wrong");
  bypass_hiz_a: assert property (bypass_active |-> !aux_clock_line_oe && !aux_data_line_oe)
    else $error("master drives while bypassed");
  take_req_a: assert property (ce && !busy && !done && start_req && master_en && !bypass_en
    && chan <= `SINGLE_CHAN |=> busy) else $error("request not taken");
  refuse_req_a: assert property (!busy && !(start_req && master_en && !bypass_en
    && chan <= `SINGLE_CHAN) |=> !busy) else $error("request not refused");
  nack_done_a: assert property (nack_err |-> ##[0:STOP_MAX] done)
    else $error("no done after nack");
  burst_len_a: assert property (rd_valid |-> rd_index < `DATA_BYTES_MAX
    && (rd_chan != `SINGLE_CHAN || rd_index == 0)) else $error("read index out of range");
  fifo_chan_a: assert property (fifo_push |-> rd_chan < `SINGLE_CHAN)
    else $error("fifo push from wrong channel");
endmodule
bind aux_sensor_i2c_master aux_master_chk #(.HALF_CYC(HALF_CYC)) u_chk (.clk(clk), .rst(rst),
  .ce(ce), .address_select_pin(address_select_pin), .spi_mode(spi_mode), .bypass_en(bypass_en),
  .master_en(master_en), .start_req(start_req), .chan(chan), .pri_scl_oe(pri_scl_oe),
  .pri_sda_oe(pri_sda_oe), .aux_clock_line_oe(aux_clock_line_oe),
  .aux_data_line_oe(aux_data_line_oe), .primary_addr(primary_addr), .bypass_active(bypass_active),
  .busy(busy), .done(done), .nack_err(nack_err), .rd_valid(rd_valid), .rd_index(rd_index),
  .rd_chan(rd_chan), .fifo_push(fifo_push));
`default_nettype wire

/* sensor_model.sv */
// behavioural external sensor on the auxiliary bus
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       nak,
  input  wire logic [7:0] base,
  output logic            sda_oe
);
  logic [7:0] sh, tx;
  logic [7:0] got [$];
  logic       rd, first;
  int         bitn, k;
  // start or repeated start restarts the byte framing
  always @(negedge sda)
    if (scl)
    begin
      bitn = 0; first = 1; rd = 0; k = 0; sda_oe = 0;
    end
  // sample on the high half; a released ack ends a burst read
  always @(posedge scl)
  begin
    if (bitn < 8) sh = {sh[6:0], sda};
    else if (rd && !first && sda) rd = 0;
    bitn++;
  end
  // answer on the low half so the line is settled before the master samples
  always @(negedge scl)
  begin
    sda_oe = 0;
    if (bitn == 8)
    begin
      if (first) rd = sh[0];
      if (first || !rd) got.push_back(sh);
      if (first || !rd) sda_oe = !nak;
    end
    else if (bitn == 9)
    begin
      bitn = 0; first = 0;
      if (rd) tx = base + k[7:0];
      if (rd) k++;
    end
    if (rd && !first && bitn < 8) sda_oe = !tx[7 - bitn];
  end
  initial {sda_oe, rd, first, bitn, k} = 0;
endmodule
`default_nettype wire

/* aux_sensor_i2c_master_test.sv */
// self-checking bench for the auxiliary sensor bus master
`timescale 1ns/1ps
`default_nettype none
`include "aux_i2c_consts.vh"
module aux_sensor_i2c_master_test;
  logic clk, rst, ce, address_select_pin, spi_mode, bypass_en, master_en, start_req;
  logic rd_not_wr, fifo_en, pri_scl_in, pri_sda_in, nak, jam, ne;
  logic [2:0] chan;
  logic [6:0] dev_addr;
  logic [7:0] reg_addr, wr_data, base;
  logic [4:0] rd_len;
  logic [31:0] rv;
  wire pri_scl_out, pri_scl_oe, pri_sda_out, pri_sda_oe, aux_scl, aux_sda, m_oe, arb_lost;
  wire aux_clock_line_out, aux_clock_line_oe, aux_data_line_out, aux_data_line_oe;
  wire bypass_active, busy, done, nack_err, rd_valid, fifo_push;
  wire [6:0] primary_addr;
  wire [7:0] rd_byte;
  wire [4:0] rd_index;
  wire [2:0] rd_chan;
  int fail_count, n_tests, nb, np, i, seed;
  // open-drain lines with pull-ups, joined to the primary pins while bypassed
  assign aux_scl = !(aux_clock_line_oe || (bypass_active && !pri_scl_in));
  assign aux_sda = !(aux_data_line_oe || m_oe || jam || (bypass_active && !pri_sda_in));
  aux_sensor_i2c_master #(.HALF_CYC(4)) u_dut (.clk(clk), .rst(rst), .ce(ce),
    .address_select_pin(address_select_pin), .spi_mode(spi_mode), .bypass_en(bypass_en),
    .master_en(master_en), .start_req(start_req), .chan(chan), .rd_not_wr(rd_not_wr),
    .dev_addr(dev_addr), .reg_addr(reg_addr), .wr_data(wr_data), .rd_len(rd_len),
    .fifo_en(fifo_en), .pri_scl_in(pri_scl_in), .pri_sda_in(pri_sda_in),
    .pri_scl_out(pri_scl_out), .pri_scl_oe(pri_scl_oe), .pri_sda_out(pri_sda_out),
    .pri_sda_oe(pri_sda_oe), .aux_clock_line_in(aux_scl), .aux_data_line_in(aux_sda),
    .aux_clock_line_out(aux_clock_line_out), .aux_clock_line_oe(aux_clock_line_oe),
    .aux_data_line_out(aux_data_line_out), .aux_data_line_oe(aux_data_line_oe),
    .primary_addr(primary_addr), .bypass_active(bypass_active), .busy(busy), .done(done),
    .nack_err(nack_err), .arb_lost(arb_lost), .rd_byte(rd_byte), .rd_index(rd_index),
    .rd_valid(rd_valid), .rd_chan(rd_chan), .fifo_push(fifo_push));
  sensor_model u_model (.scl(aux_scl), .sda(aux_sda), .nak(nak), .base(base), .sda_oe(m_oe));
  always #12.5 clk = !clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    n_tests++;
    if (a !== e) fail_count++;
    if (a !== e) $display("ERROR t=%0t got=%h exp=%h", $time, a, e);
  endtask
  function automatic int exp_len(input logic [2:0] c, input logic [4:0] n);
    return (c == `SINGLE_CHAN || n == 0) ? 1 : (n > `DATA_BYTES_MAX) ? `DATA_BYTES_MAX : n;
  endfunction
  // one request, then wait for completion while collecting read bytes
  task automatic xfer(input logic [2:0] c, input logic r, input logic [4:0] n);
    rv = $random(seed);
    {dev_addr, reg_addr, wr_data, fifo_en} = rv[23:0];
    {chan, rd_not_wr, rd_len, base, nb, np, ne, start_req} = {c, r, n, rv[31:24], 66'h1};
    u_model.got.delete();
    @(posedge clk) #2;
    start_req = 0;
    for (i = 0; i < 5000 && !(done || arb_lost); i++)
    begin
      @(posedge clk) #2;
      if (rd_valid) chk(rd_byte, base + nb[7:0]);
      {nb, np, ne} = {nb + rd_valid, np + fifo_push, ne | nack_err};
    end
    if (i == 5000) fail_count++;
  endtask
  task automatic run(input logic [2:0] c, input logic r, input logic [4:0] n);
    xfer(c, r, n);
    chk(u_model.got[0], {dev_addr, 1'b0});
    chk(u_model.got[1], reg_addr);
    chk(u_model.got[2], r ? {dev_addr, 1'b1} : wr_data);
    chk(8'(nb), r ? 8'(exp_len(c, n)) : 8'h0);
    chk(8'(np), (fifo_en && c != `SINGLE_CHAN) ? 8'(nb) : 8'h0);
    chk(8'({done, ne}), 8'h2);
    $display("test chan=%0d rd=%0d len=%0d ended", c, r, n);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog well beyond the longest expected run
  initial
  begin
    #2000000;
    fail_count++;
    tally_and_finish();
  end
  initial
  begin
    {clk, address_select_pin, spi_mode, bypass_en, start_req, nak, jam, chan, rd_not_wr} = 0;
    {dev_addr, reg_addr, wr_data, rd_len, fifo_en, base, fail_count, n_tests} = 0;
    {rst, ce, master_en, pri_scl_in, pri_sda_in, seed} = {5'h1f, 32'hd21d};
    repeat (12) @(posedge clk);
    #2 rst = 0;
    for (int p = 0; p < 2; p++)
    begin
      address_select_pin = p[0];
      repeat (5) @(posedge clk);
      #2 chk(8'(primary_addr), {1'b0, `PRIMARY_ADDR_HI, p[0]});
    end
    run(0, 0, 1); run(1, 1, 24); run(2, 1, 31); run(4, 1, 5); run(4, 0, 0); run(3, 1, 0);
    for (int t = 0; t < 6; t++) run({1'b0, t[1:0]}, $random(seed), $random(seed));
    nak = 1;
    xfer(1, 0, 1);
    chk(8'({done, ne}), 8'h3);
    {nak, jam} = 2'b01;
    xfer(0, 0, 1);
    chk(8'({arb_lost, done}), 8'h2);
    {jam, start_req, chan} = 5'b01101;
    repeat (3) @(posedge clk);
    #2 chk(8'(busy), 8'h0);
    {chan, ce} = 0;
    repeat (3) @(posedge clk);
    #2 chk(8'(busy), 8'h0);
    {ce, master_en} = 2'b10;
    repeat (3) @(posedge clk);
    #2 chk(8'(busy), 8'h0);
    // data falls first, so the sensor sees a start and drops its old framing
    {master_en, bypass_en, pri_sda_in} = 3'b110;
    repeat (3) @(posedge clk);
    #2 chk(8'({busy, bypass_active, aux_scl, aux_sda}), 8'h6);
    pri_scl_in = 0;
    @(posedge clk);
    #2 chk(8'({aux_scl, aux_sda}), 8'h0);
    spi_mode = 1;
    #1 chk(8'({bypass_active, aux_scl, aux_sda}), 8'h3);
    {spi_mode, bypass_en, pri_scl_in, pri_sda_in} = 4'b0011;
    $display("test refusal and bypass ended");
    run(2, 1, 2);
    tally_and_finish();
  end
endmodule
`default_nettype wire
